// file: logic/rrs_pkg.sv
// package: register map, field layout, states and bus carriers of the radio rx status bank
package rrs_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CRC_RESULT    = 12'h400;
  localparam logic [11:0] OFS_RX_ADDR_MATCH = 12'h408;
  localparam logic [11:0] OFS_RX_CHECKSUM   = 12'h40c;
  localparam logic [11:0] OFS_DEV_MATCH_IDX = 12'h410;
  localparam logic [11:0] OFS_PAYLOAD_STAT  = 12'h414;
  localparam logic [11:0] OFS_TONE_EXT_INFO = 12'h44c;
  localparam logic [11:0] OFS_DF_STATUS     = 12'h458;
  localparam logic [11:0] OFS_PACKET_PTR    = 12'h504;
  localparam logic [11:0] OFS_IRQ_STATUS    = 12'h600;
  localparam logic [11:0] OFS_IRQ_MASK      = 12'h604;

  // field widths and positions
  localparam int MATCH_W      = 3;
  localparam int CHECKSUM_W   = 24;
  localparam int TE_TIME_W    = 5;
  localparam int TE_TIME_POS  = 0;
  localparam int TE_RSV_POS   = 5;
  localparam int TE_TYPE_W    = 2;
  localparam int TE_TYPE_POS  = 6;
  localparam int SW_STATE_W   = 3;
  localparam int SW_STATE_POS = 0;
  localparam int SAMPLE_POS   = 4;
  localparam int IRQ_W        = 3;
  localparam int IRQ_RX_DONE  = 0;
  localparam int IRQ_CRC_FAIL = 1;
  localparam int IRQ_TONE_EXT = 2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // checksum result encoding
  localparam logic CHECKSUM_FAILED = 1'b0;
  localparam logic CHECKSUM_PASSED = 1'b1;

  // antenna switching state codes
  localparam logic [SW_STATE_W-1:0] SW_IDLE      = 3'h0;
  localparam logic [SW_STATE_W-1:0] SW_OFFSET    = 3'h1;
  localparam logic [SW_STATE_W-1:0] SW_GUARD     = 3'h2;
  localparam logic [SW_STATE_W-1:0] SW_REFERENCE = 3'h3;
  localparam logic [SW_STATE_W-1:0] SW_SWITCHING = 3'h4;
  localparam logic [SW_STATE_W-1:0] SW_ENDING    = 3'h5;

  // sampler state codes
  localparam logic SAMPLER_IDLE     = 1'b0;
  localparam logic SAMPLER_SAMPLING = 1'b1;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK,
    BUS_DROP
  } rrs_bus_state_t;

  // result of one finished reception, strobed by the radio datapath
  typedef struct packed {
    logic                  checksum_ok;
    logic [MATCH_W-1:0]    match_addr;
    logic [CHECKSUM_W-1:0] checksum;
    logic                  tone_ext_present;
    logic [7:0]            tone_ext_raw;
  } rrs_rx_result_t;

  // live direction-finding machine states
  typedef struct packed {
    logic [SW_STATE_W-1:0] antenna_switch_state;
    logic                  sampler_state;
  } rrs_df_state_t;

endpackage : rrs_pkg

// file: logic/rrs_regs.sv
// radio receive status and packet pointer register bank
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps

// Behaviour
// (RULE1) after each reception, one read-only bit: 0 checksum failed, 1 passed
// (RULE2) hold the logical address index matched by the latest received packet
// (RULE3) capture the latest packet checksum field, held until the next reception
// (RULE4) parse tone-extension info into separate time, reserved and type fields
// (RULE5) show antenna switching state: idle 0 to ending 5
// (RULE6) show sampler state as one bit: 0 idle, 1 sampling
// (RULE7) datapath fetches or stores packets at the byte address in packet pointer
module rrs_regs
  import rrs_pkg::*;
#(
  parameter logic [31:0] DEV_MATCH_IDX_VAL = 32'h0000_0000,
  parameter logic [31:0] PAYLOAD_STAT_VAL  = 32'h0000_0000
) (
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // wishbone slave
  input  wire logic           cyc_i,
  input  wire logic           stb_i,
  input  wire logic           we_i,
  input  wire logic [11:0]    adr_i,
  input  wire logic [3:0]     sel_i,
  input  wire logic [31:0]    dat_i,
  output logic                ack_o,
  output logic [31:0]         dat_o,
  // radio datapath
  input  wire logic           rx_done_i,
  input  wire rrs_rx_result_t rx_result_i,
  input  wire rrs_df_state_t  df_state_i,
  output logic [31:0]         packet_ram_pointer_o,
  // interrupt
  output logic                irq_o
);

  typedef struct packed {
    logic                  checksum_result;
    logic [MATCH_W-1:0]    matched_logical_address;
    logic [CHECKSUM_W-1:0] received_checksum_field;
    logic [TE_TIME_W-1:0]  tone_ext_time;
    logic                  tone_ext_reserved;
    logic [TE_TYPE_W-1:0]  tone_ext_type;
    logic [31:0]           packet_ram_pointer;
    logic [IRQ_W-1:0]      irq_status;
    logic [IRQ_W-1:0]      irq_mask;
  } rrs_reg_state_t;

  rrs_reg_state_t r;
  rrs_reg_state_t next_r;

  logic             rd_pulse;
  logic             wr_pulse;
  logic [11:0]      acc_adr;
  logic [31:0]      rd_data;
  logic [31:0]      wr_merged;
  logic [IRQ_W-1:0] irq_events;

  // reception result split into its fields; tone fields parsed from the raw byte
  logic                  rx_checksum_ok;
  logic [MATCH_W-1:0]    rx_match_addr;
  logic [CHECKSUM_W-1:0] rx_checksum;
  logic                  rx_te_present;
  logic [TE_TIME_W-1:0]  rx_te_time;
  logic                  rx_te_reserved;
  logic [TE_TYPE_W-1:0]  rx_te_type;

  // one-hot decode of the bus address
  logic             hit_checksum_result;
  logic             hit_rx_address_match;
  logic             hit_rx_checksum_value;
  logic             hit_device_match_index;
  logic             hit_payload_status;
  logic             hit_tone_extension_info;
  logic             hit_direction_finding_status;
  logic             hit_packet_ram_pointer;
  logic             hit_irq_status;
  logic             hit_irq_mask;

  // write strobes, and the status read that clears
  logic             wr_packet_ram_pointer;
  logic             wr_irq_mask;
  logic             rd_irq_status;

  // read word of every register
  logic [31:0]      checksum_result_word;
  logic [31:0]      rx_address_match_word;
  logic [31:0]      rx_checksum_value_word;
  logic [31:0]      device_match_index_word;
  logic [31:0]      payload_status_word;
  logic [31:0]      tone_extension_info_word;
  logic [31:0]      direction_finding_status_word;
  logic [31:0]      packet_ram_pointer_word;
  logic [31:0]      irq_status_word;
  logic [31:0]      irq_mask_word;

  // interrupt sources both pending and enabled
  logic [IRQ_W-1:0] irq_pending;

  rrs_wb_slave u_rrs_wb_slave (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cyc_i      (cyc_i),
    .stb_i      (stb_i),
    .we_i       (we_i),
    .adr_i      (adr_i),
    .ack_o      (ack_o),
    .dat_o      (dat_o),
    .rd_pulse_o (rd_pulse),
    .wr_pulse_o (wr_pulse),
    .acc_adr_o  (acc_adr),
    .rd_data_i  (rd_data)
  );

  // byte lanes merge onto the current pointer value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_merged[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : r.packet_ram_pointer[b*8 +: 8];
    end
  end

  // field split of the reception result
  always_comb begin
    rx_checksum_ok = rx_result_i.checksum_ok;
    rx_match_addr  = rx_result_i.match_addr;
    rx_checksum    = rx_result_i.checksum;
    rx_te_present  = rx_result_i.tone_ext_present;
    rx_te_time     = rx_result_i.tone_ext_raw[TE_TIME_POS +: TE_TIME_W]; // see (RULE4)
    rx_te_reserved = rx_result_i.tone_ext_raw[TE_RSV_POS]; // see (RULE4)
    rx_te_type     = rx_result_i.tone_ext_raw[TE_TYPE_POS +: TE_TYPE_W]; // see (RULE4)
  end

  // full offsets are compared, so aliases of a register read as unmapped
  always_comb begin
    hit_checksum_result          = (acc_adr == OFS_CRC_RESULT);
    hit_rx_address_match         = (acc_adr == OFS_RX_ADDR_MATCH);
    hit_rx_checksum_value        = (acc_adr == OFS_RX_CHECKSUM);
    hit_device_match_index       = (acc_adr == OFS_DEV_MATCH_IDX);
    hit_payload_status           = (acc_adr == OFS_PAYLOAD_STAT);
    hit_tone_extension_info      = (acc_adr == OFS_TONE_EXT_INFO);
    hit_direction_finding_status = (acc_adr == OFS_DF_STATUS);
    hit_packet_ram_pointer       = (acc_adr == OFS_PACKET_PTR);
    hit_irq_status               = (acc_adr == OFS_IRQ_STATUS);
    hit_irq_mask                 = (acc_adr == OFS_IRQ_MASK);
  end

  // writes to read-only offsets are acked and change nothing
  always_comb begin
    wr_packet_ram_pointer = wr_pulse && hit_packet_ram_pointer;
    wr_irq_mask           = wr_pulse && hit_irq_mask && sel_i[0];
    rd_irq_status         = rd_pulse && hit_irq_status;
  end

  always_comb begin
    irq_events               = '0;
    irq_events[IRQ_RX_DONE]  = rx_done_i;
    irq_events[IRQ_CRC_FAIL] = rx_done_i && (rx_result_i.checksum_ok == CHECKSUM_FAILED);
    irq_events[IRQ_TONE_EXT] = rx_done_i && rx_result_i.tone_ext_present;
  end

  // read words; bits without a field read as zero
  always_comb begin
    checksum_result_word    = RESET_WORD;
    checksum_result_word[0] = r.checksum_result; // see (RULE1)
  end

  always_comb begin
    rx_address_match_word              = RESET_WORD;
    rx_address_match_word[MATCH_W-1:0] = r.matched_logical_address; // see (RULE2)
  end

  always_comb begin
    rx_checksum_value_word                 = RESET_WORD;
    rx_checksum_value_word[CHECKSUM_W-1:0] = r.received_checksum_field; // see (RULE3)
  end

  // index and payload layouts are not modelled, so they read a fixed word
  assign device_match_index_word = DEV_MATCH_IDX_VAL;
  assign payload_status_word     = PAYLOAD_STAT_VAL;

  always_comb begin
    tone_extension_info_word                           = RESET_WORD;
    tone_extension_info_word[TE_TIME_POS +: TE_TIME_W] = r.tone_ext_time; // see (RULE4)
    tone_extension_info_word[TE_RSV_POS]               = r.tone_ext_reserved; // see (RULE4)
    tone_extension_info_word[TE_TYPE_POS +: TE_TYPE_W] = r.tone_ext_type; // see (RULE4)
  end

  // live machine states, not registered here: the bus slave takes them at the request edge
  always_comb begin
    direction_finding_status_word                             = RESET_WORD;
    direction_finding_status_word[SW_STATE_POS +: SW_STATE_W] = df_state_i.antenna_switch_state; // see (RULE5)
    direction_finding_status_word[SAMPLE_POS]                 = df_state_i.sampler_state; // see (RULE6)
  end

  assign packet_ram_pointer_word = r.packet_ram_pointer;

  always_comb begin
    irq_status_word            = RESET_WORD;
    irq_status_word[IRQ_W-1:0] = r.irq_status;
  end

  always_comb begin
    irq_mask_word            = RESET_WORD;
    irq_mask_word[IRQ_W-1:0] = r.irq_mask;
  end

  // read mux over the one-hot decode; no hit reads as unmapped
  always_comb begin
    rd_data = UNMAPPED_READ;
    if (hit_checksum_result) begin
      rd_data = checksum_result_word;
    end else if (hit_rx_address_match) begin
      rd_data = rx_address_match_word;
    end else if (hit_rx_checksum_value) begin
      rd_data = rx_checksum_value_word;
    end else if (hit_device_match_index) begin
      rd_data = device_match_index_word;
    end else if (hit_payload_status) begin
      rd_data = payload_status_word;
    end else if (hit_tone_extension_info) begin
      rd_data = tone_extension_info_word;
    end else if (hit_direction_finding_status) begin
      rd_data = direction_finding_status_word;
    end else if (hit_packet_ram_pointer) begin
      rd_data = packet_ram_pointer_word;
    end else if (hit_irq_status) begin
      rd_data = irq_status_word;
    end else if (hit_irq_mask) begin
      rd_data = irq_mask_word;
    end
  end

  always_comb begin
    next_r = r;
    if (rx_done_i) begin
      next_r.checksum_result         = rx_checksum_ok; // see (RULE1)
      next_r.matched_logical_address = rx_match_addr; // see (RULE2)
      next_r.received_checksum_field = rx_checksum; // see (RULE3)
      // a packet without tone extension clears the old fields rather than keeping stale ones
      next_r.tone_ext_time           = rx_te_present ? rx_te_time : '0; // see (RULE4)
      next_r.tone_ext_reserved       = rx_te_present ? rx_te_reserved : 1'b0; // see (RULE4)
      next_r.tone_ext_type           = rx_te_present ? rx_te_type : '0; // see (RULE4)
    end
    if (wr_packet_ram_pointer) begin
      next_r.packet_ram_pointer = wr_merged; // see (RULE7)
    end
    if (wr_irq_mask) begin
      next_r.irq_mask = dat_i[IRQ_W-1:0];
    end
    // read clears status; an event in the same cycle survives
    for (int i = 0; i < IRQ_W; i++) begin
      if (irq_events[i]) begin
        next_r.irq_status[i] = 1'b1;
      end else if (rd_irq_status) begin
        next_r.irq_status[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // datapath reads the pointer directly for fetch on transmit and store on receive
  assign packet_ram_pointer_o = r.packet_ram_pointer; // see (RULE7)
  assign irq_pending          = r.irq_status & r.irq_mask;
  assign irq_o                = |irq_pending;

endmodule : rrs_regs

// file: logic/rrs_wb_slave.sv
// classic wishbone slave front end: one ack per request, at most one every three cycles, read data registered
`timescale 1ns/1ps
module rrs_wb_slave
  import rrs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // register access
  output logic             rd_pulse_o,
  output logic             wr_pulse_o,
  output logic [11:0]      acc_adr_o,
  input  wire logic [31:0] rd_data_i
);

  typedef struct packed {
    rrs_bus_state_t st;
    logic [31:0]    dat;
  } rrs_wb_state_t;

  rrs_wb_state_t s;
  rrs_wb_state_t next_s;

  logic take;

  // a request is taken from idle only; ack falls the cycle after it rose even if stb stays, and a stb still held is taken again after drop
  assign take       = (s.st == BUS_IDLE) && cyc_i && stb_i;
  assign rd_pulse_o = take && !we_i;
  assign wr_pulse_o = take && we_i;
  assign acc_adr_o  = adr_i;
  assign ack_o      = (s.st == BUS_ACK);
  assign dat_o      = s.dat;

  always_comb begin
    next_s = s;
    case (s.st)
      BUS_IDLE: begin
        if (take) begin
          next_s.st  = BUS_ACK;
          next_s.dat = we_i ? RESET_WORD : rd_data_i;
        end
      end
      BUS_ACK: begin
        next_s.st = BUS_DROP;
      end
      BUS_DROP: begin
        next_s.st = BUS_IDLE;
      end
      default: begin
        next_s.st = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{st: BUS_IDLE, dat: RESET_WORD};
    end else begin
      s <= next_s;
    end
  end

endmodule : rrs_wb_slave

// file: sim/rrs_regs_assertions.sv
// checker: bus handshake, read-back and packet pointer of the rx status bank
`timescale 1ns/1ps
module rrs_regs_chk
  import rrs_pkg::*;
(
  // watched ports
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           cyc_i,
  input wire logic           stb_i,
  input wire logic           we_i,
  input wire logic [11:0]    adr_i,
  input wire logic [3:0]     sel_i,
  input wire logic [31:0]    dat_i,
  input wire logic           ack_o,
  input wire logic [31:0]    dat_o,
  input wire logic           rx_done_i,
  input wire rrs_rx_result_t rx_result_i,
  input wire rrs_df_state_t  df_state_i,
  input wire logic [31:0]    packet_ram_pointer_o,
  input wire logic           irq_o
);
  rrs_rx_result_t lr;
  logic           rd;
  assign rd = ack_o && !we_i;
  // shadow of the last reception; read data lags it by the taking edge
  always_ff @(posedge clk_i) begin
    if (rst_i) lr <= '0;
    else if (rx_done_i) lr <= rx_result_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; ack_o |=> !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_crc; rd && adr_i == OFS_CRC_RESULT |-> dat_o == {31'h0, $past(lr.checksum_ok)}; endproperty
  a_crc: assert property (p_crc) else $error("checksum result wrong");
  property p_match; rd && adr_i == OFS_RX_ADDR_MATCH |-> dat_o == {29'h0, $past(lr.match_addr)}; endproperty
  a_match: assert property (p_match) else $error("matched address wrong");
  property p_cks; rd && adr_i == OFS_RX_CHECKSUM |-> dat_o == {8'h0, $past(lr.checksum)}; endproperty
  a_cks: assert property (p_cks) else $error("checksum field wrong");
  property p_te; rd && adr_i == OFS_TONE_EXT_INFO |->
    dat_o == ($past(lr.tone_ext_present) ? {24'h0, $past(lr.tone_ext_raw)} : 32'h0); endproperty
  a_te: assert property (p_te) else $error("tone extension fields wrong");
  property p_df; rd && adr_i == OFS_DF_STATUS |->
    dat_o == {27'h0, $past(df_state_i.sampler_state), 1'b0, $past(df_state_i.antenna_switch_state)}; endproperty
  a_df: assert property (p_df) else $error("direction finding status wrong");
  property p_ptr_wr; ack_o && we_i && adr_i == OFS_PACKET_PTR && sel_i == 4'hf |-> packet_ram_pointer_o == dat_i;
  endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("pointer not written");
  property p_ptr_hold; !(cyc_i && stb_i && we_i) |=> $stable(packet_ram_pointer_o); endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed without write");
  c_rx: cover property (rx_done_i);
  c_wr: cover property (ack_o && we_i);
  c_irq: cover property ($rose(irq_o));
endmodule : rrs_regs_chk

bind rrs_regs rrs_regs_chk u_rrs_regs_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
  .ack_o, .dat_o, .rx_done_i, .rx_result_i, .df_state_i, .packet_ram_pointer_o, .irq_o);

// file: sim/rrs_regs_test.sv
// testbench: random receptions, register read-back, pointer and interrupt
`timescale 1ns/1ps
module rrs_regs_test
  import rrs_pkg::*;
;
  logic           clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, rx_done_i = 0;
  logic [11:0]    adr_i = '0;
  logic [3:0]     sel_i = '0;
  logic [31:0]    dat_i = '0, dat_o, packet_ram_pointer_o, q, p, sd = 32'h8e9c;
  logic           ack_o, irq_o;
  rrs_rx_result_t rx_result_i = '0, r;
  rrs_df_state_t  df_state_i = '0;
  int             n_mismatch = 0, checks = 0;
  logic [11:0]    ofs [10] = '{OFS_CRC_RESULT, OFS_RX_ADDR_MATCH, OFS_RX_CHECKSUM, OFS_DEV_MATCH_IDX,
    OFS_PAYLOAD_STAT, OFS_TONE_EXT_INFO, OFS_DF_STATUS, OFS_PACKET_PTR, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  always #5 clk_i = ~clk_i;
  rrs_regs u_rrs_regs (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .dat_o,
    .rx_done_i, .rx_result_i, .df_state_i, .packet_ram_pointer_o, .irq_o);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [31:0] expw(input logic [11:0] a, input rrs_rx_result_t x);
    case (a)
      OFS_CRC_RESULT: return {31'h0, x.checksum_ok};
      OFS_RX_ADDR_MATCH: return {29'h0, x.match_addr};
      OFS_RX_CHECKSUM: return {8'h0, x.checksum};
      default: return x.tone_ext_present ? {24'h0, x.tone_ext_raw} : 32'h0;
    endcase
  endfunction : expw
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmpb(input string nm, input logic e, input logic g);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask : cmpb
  // one classic cycle; entered just after a rising edge, holds until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      n_mismatch++;
      results();
    end else begin
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask : wb
  task automatic rx(input rrs_rx_result_t x);
    rx_done_i <= 1'b1;
    rx_result_i <= x;
    @(posedge clk_i);
    rx_done_i <= 1'b0;
    // inverted afterwards so a late capture shows up
    rx_result_i <= ~x;
    @(posedge clk_i);
  endtask : rx
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ofs[i]) begin
      wb(0, ofs[i], sd, 4'hf);
      cmp("reset value", RESET_WORD, q);
    end
    p = lfsr(sd);
    wb(1, OFS_PACKET_PTR, p, 4'hf);
    cmp("pointer out", p, packet_ram_pointer_o);
    wb(1, OFS_PACKET_PTR, ~p, 4'h3);
    wb(0, OFS_PACKET_PTR, '0, 4'hf);
    cmp("pointer lanes", {p[31:16], ~p[15:0]}, q);
    wb(1, OFS_CRC_RESULT, 32'hffff_ffff, 4'hf);
    wb(0, OFS_CRC_RESULT, '0, 4'hf);
    cmp("read-only write", 32'h0, q);
    wb(0, 12'h700, '0, 4'hf);
    cmp("unmapped", UNMAPPED_READ, q);
    wb(1, OFS_IRQ_MASK, 32'h7, 4'h1);
    wb(1, OFS_IRQ_MASK, 32'h0, 4'he);
    wb(0, OFS_IRQ_MASK, '0, 4'hf);
    cmp("irq mask", 32'h7, q);
    for (int i = 0; i < 8; i++) begin
      sd = lfsr(sd);
      r = rrs_rx_result_t'({sd[4:0], sd});
      r.tone_ext_present = i[0];
      r.checksum_ok = i[1];
      rx(r);
      cmpb("irq level", 1'b1, irq_o);
      foreach (ofs[j]) if (j < 3 || j == 5) begin
        wb(0, ofs[j], '0, 4'hf);
        cmp("rx result", expw(ofs[j], r), q);
      end
      wb(0, OFS_IRQ_STATUS, '0, 4'hf);
      cmp("irq status", {29'h0, r.tone_ext_present, ~r.checksum_ok, 1'b1}, q);
      cmpb("irq cleared", 1'b0, irq_o);
    end
    wb(1, OFS_IRQ_MASK, 32'h0, 4'h1);
    rx(r);
    cmpb("masked irq", 1'b0, irq_o);
    for (int k = 0; k < 12; k++) begin
      df_state_i <= {3'(k % 6), 1'(k / 6)};
      wb(0, OFS_DF_STATUS, '0, 4'hf);
      cmp("df status", {27'h0, 1'(k / 6), 1'b0, 3'(k % 6)}, q);
    end
    results();
  end
endmodule : rrs_regs_test
